//--- rtl/lmp_ctrl.sv
// Summary of operation
// - Format 6: one octet per lane, two lanes
// - Format 7: one octet per lane, four lanes
// - Format 9: one 16-bit sample per lane
// - Format 10: I lane 0, Q lane 1
// - Format 11: I0 I1 Q0 Q1 on four lanes
// - Format 12: five 12-bit samples plus tail nibble
// - Format 13: I then Q on lane 0
// - Format 14: I lane 0, Q lane 1
// - Format 15: AI AQ BI BQ on one lane
// - Format 16: I then Q per link lane 0
// - Format 17: even samples link A, odd link B
// - Format 18: octet of sample k on lane k of each link
// - One route select routes the other channel to both paths, both selects swap them
// - Redundant routing blocked in single-channel formats
// - Channel powerdown kills that link's lanes
// - Powerdown pin disables drivers and all serializers
// - Power mode beyond 0 or 1 kills serializers
// - Lanes unused by the format are off
// - Keepalive on both links keeps spare lanes on
// - Test select picks mode, power follows format
`timescale 1ns/1ns
`default_nettype none
`include "lmp_params.svh"

// ****************************************
// Frame buffer
// ****************************************
module lmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `LMP_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } lmp_fifo_state_type;
  lmp_fifo_state_type st;
  lmp_fifo_state_type next_st;
  logic push;
  logic pop;

  assign in_ready = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + AW'(1);
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ****************************************
// Lane mapper, power and test control
// ****************************************
module lmp_ctrl (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`LMP_SAMPS*`LMP_SAMP_W-1:0] samp_a_i,
  input wire logic [`LMP_SAMPS*`LMP_SAMP_W-1:0] samp_a_q,
  input wire logic [`LMP_SAMPS*`LMP_SAMP_W-1:0] samp_b_i,
  input wire logic [`LMP_SAMPS*`LMP_SAMP_W-1:0] samp_b_q,
  input wire logic [4:0] link_format_select,
  input wire logic chan_a_route_select,
  input wire logic chan_b_route_select,
  input wire logic chan_a_powerdown,
  input wire logic chan_b_powerdown,
  input wire logic full_powerdown_pin,
  input wire logic [7:0] device_power_mode,
  input wire logic spare_lane_keepalive_a,
  input wire logic spare_lane_keepalive_b,
  input wire logic [3:0] test_pattern_select,
  output logic lane_valid,
  input wire logic lane_ready,
  output logic [`LMP_LANES*`LMP_LANE_W-1:0] lane_data,
  output logic [3:0] frame_octets,
  output logic [`LMP_LANES-1:0] lane_power,
  output logic test_mode_active
);
  localparam int SW = `LMP_SAMPS*`LMP_SAMP_W;
  localparam int LW = `LMP_LANE_W;
  localparam int HALF = `LMP_LANES/2;

  lmp_pkg::lmp_top_state_type st;
  lmp_pkg::lmp_top_state_type next_st;
  logic head_valid;
  logic head_ready;
  logic [4*SW-1:0] head;
  logic [SW-1:0] h_ai;
  logic [SW-1:0] h_aq;
  logic [SW-1:0] h_bi;
  logic [SW-1:0] h_bq;
  logic pop;
  logic dual;
  logic all_off;
  logic keep;
  logic [3:0] used_a;
  logic [3:0] used_b;
  lmp_pkg::lmp_lanes_type mapped;

  // ****************************************
  // Format decode
  // ****************************************
  // Lanes per link in use, zero for codes outside the table
  function automatic logic [3:0] lmp_lanes_used(input lmp_pkg::lmp_fmt_type f, input logic link_b);
    logic [3:0] n;
    n = 4'h0;
    case (f)
      `LMP_FMT_6, `LMP_FMT_10, `LMP_FMT_14: n = 4'h2;
      `LMP_FMT_7, `LMP_FMT_9, `LMP_FMT_11: n = 4'h4;
      `LMP_FMT_12, `LMP_FMT_17, `LMP_FMT_18: n = 4'h8;
      `LMP_FMT_13, `LMP_FMT_16: n = 4'h1;
      `LMP_FMT_15: n = link_b ? 4'h0 : 4'h1;
      default: n = 4'h0;
    endcase
    return n;
  endfunction

  function automatic logic [3:0] lmp_octets(input lmp_pkg::lmp_fmt_type f);
    logic [3:0] n;
    n = 4'h1;
    case (f)
      `LMP_FMT_9, `LMP_FMT_10, `LMP_FMT_11, `LMP_FMT_14: n = 4'h2;
      `LMP_FMT_13, `LMP_FMT_16: n = 4'h4;
      `LMP_FMT_12, `LMP_FMT_15: n = 4'h8;
      default: n = 4'h1;
    endcase
    return n;
  endfunction

  // Octet 0 is the first one sent and sits in the top byte of each lane word
  function automatic lmp_pkg::lmp_lanes_type lmp_map(
    input lmp_pkg::lmp_fmt_type f,
    input lmp_pkg::lmp_samps_type ai,
    input lmp_pkg::lmp_samps_type aq,
    input lmp_pkg::lmp_samps_type bi,
    input lmp_pkg::lmp_samps_type bq
  );
    lmp_pkg::lmp_lanes_type r;
    r = '0;
    case (f)
      `LMP_FMT_6, `LMP_FMT_7, `LMP_FMT_18: begin
        for (int k = 0; k < HALF; k++) begin
          r[k*LW+56 +: 8] = ai[k*16 +: 8];
          r[(k+HALF)*LW+56 +: 8] = bi[k*16 +: 8];
        end
      end
      `LMP_FMT_17: begin
        for (int k = 0; k < HALF; k++) begin
          r[k*LW+56 +: 8] = ai[(2*k)*16 +: 8];
          r[(k+HALF)*LW+56 +: 8] = ai[(2*k+1)*16 +: 8];
        end
      end
      `LMP_FMT_9: begin
        for (int k = 0; k < 4; k++) begin
          r[k*LW+48 +: 16] = ai[k*16 +: 16];
          r[(k+HALF)*LW+48 +: 16] = bi[k*16 +: 16];
        end
      end
      `LMP_FMT_10, `LMP_FMT_14: begin
        r[0*LW+48 +: 16] = ai[0 +: 16];
        r[1*LW+48 +: 16] = aq[0 +: 16];
        r[HALF*LW+48 +: 16] = bi[0 +: 16];
        r[(HALF+1)*LW+48 +: 16] = bq[0 +: 16];
      end
      `LMP_FMT_11: begin
        for (int k = 0; k < 2; k++) begin
          r[k*LW+48 +: 16] = ai[k*16 +: 16];
          r[(k+2)*LW+48 +: 16] = aq[k*16 +: 16];
          r[(k+HALF)*LW+48 +: 16] = bi[k*16 +: 16];
          r[(k+HALF+2)*LW+48 +: 16] = bq[k*16 +: 16];
        end
      end
      `LMP_FMT_12: begin
        // Tail nibble is left at zero
        for (int k = 0; k < 4; k++) begin
          for (int j = 0; j < 5; j++) begin
            r[(2*k)*LW+52-12*j +: 12] = ai[(k+4*j)*16 +: 12];
            r[(2*k+1)*LW+52-12*j +: 12] = aq[(k+4*j)*16 +: 12];
            r[(2*k+HALF)*LW+52-12*j +: 12] = bi[(k+4*j)*16 +: 12];
            r[(2*k+1+HALF)*LW+52-12*j +: 12] = bq[(k+4*j)*16 +: 12];
          end
        end
      end
      `LMP_FMT_13, `LMP_FMT_16: begin
        r[0*LW+32 +: 32] = {ai[0 +: 16], aq[0 +: 16]};
        r[HALF*LW+32 +: 32] = {bi[0 +: 16], bq[0 +: 16]};
      end
      `LMP_FMT_15: begin
        r[0 +: LW] = {ai[0 +: 16], aq[0 +: 16], bi[0 +: 16], bq[0 +: 16]};
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Input buffering
  // ****************************************
  lmp_fifo #(
    .WIDTH(4*SW),
    .DEPTH(`LMP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data({samp_b_q, samp_b_i, samp_a_q, samp_a_i}),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head)
  );

  // ****************************************
  // Routing and power decode
  // ****************************************
  // Single-channel formats ignore binding, a bound copy would be meaningless
  assign dual = (link_format_select != `LMP_FMT_17);
  assign h_ai = (dual && chan_a_route_select) ? head[2*SW +: SW] : head[0 +: SW];
  assign h_aq = (dual && chan_a_route_select) ? head[3*SW +: SW] : head[SW +: SW];
  assign h_bi = (dual && chan_b_route_select) ? head[0 +: SW] : head[2*SW +: SW];
  assign h_bq = (dual && chan_b_route_select) ? head[SW +: SW] : head[3*SW +: SW];
  assign mapped = lmp_map(link_format_select, h_ai, h_aq, h_bi, h_bq);

  // Lane word is held while the pin is high, so no frame is lost in a short outage
  assign lane_valid = st.out_valid & ~st.pd_sync;
  assign head_ready = ~st.out_valid | (lane_ready & lane_valid);
  assign pop = head_valid & head_ready;

  assign all_off = st.pd_sync | ((device_power_mode != `LMP_PMODE_RUN0) &&
                   (device_power_mode != `LMP_PMODE_RUN1));
  // Spare serializers toggle only with both links asking, at extra core current
  assign keep = spare_lane_keepalive_a & spare_lane_keepalive_b;
  assign used_a = lmp_lanes_used(link_format_select, 1'b0);
  assign used_b = lmp_lanes_used(link_format_select, 1'b1);
  assign test_mode_active = (test_pattern_select != 4'h0);

  always_comb begin
    next_st = st;
    next_st.pd_meta = full_powerdown_pin;
    next_st.pd_sync = st.pd_meta;
    for (int k = 0; k < HALF; k++) begin
      // Power follows the format in every test mode
      next_st.lane_power[k] = ~all_off & ~chan_a_powerdown & ((4'(k) < used_a) | keep);
      next_st.lane_power[k+HALF] = ~all_off & ~chan_b_powerdown & ((4'(k) < used_b) | keep);
    end
    if (pop) begin
      next_st.out_valid = 1'b1;
      next_st.frame_octets = lmp_octets(link_format_select);
      if (test_mode_active) begin
        // Test content is a simple per-frame count; caller keeps the link down meanwhile
        next_st.lane_data = {(`LMP_LANES*LW/8){st.ramp}};
        next_st.ramp = st.ramp + 8'h01;
      end else begin
        next_st.lane_data = mapped;
      end
    end else if (lane_ready && lane_valid) begin
      next_st.out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
      st.ramp <= `LMP_RST_RAMP;
      st.lane_power <= `LMP_RST_POWER;
    end else begin
      st <= next_st;
    end
  end

  assign lane_data = st.lane_data;
  assign frame_octets = st.frame_octets;
  assign lane_power = st.lane_power;

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] chk_ai0;
  logic [7:0] chk_ai1;
  logic [63:0] chk_f15;
  logic norm;
  assign chk_ai0 = head[0 +: 8];
  assign chk_ai1 = head[16 +: 8];
  assign chk_f15 = {head[0 +: 16], head[SW +: 16], head[2*SW +: 16], head[3*SW +: 16]};
  assign norm = ~st.pd_sync & ~chan_a_powerdown & ~chan_b_powerdown &
                (device_power_mode == `LMP_PMODE_RUN0);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_pop_plain;
    pop && !test_mode_active && !chan_a_route_select && !chan_b_route_select;
  endsequence
  sequence s_pop_f6;
    s_pop_plain ##0 (link_format_select == `LMP_FMT_6);
  endsequence

  property p_fmt6;
    s_pop_f6 |=> (lane_valid || st.pd_sync) && (lane_data[56 +: 8] == $past(chk_ai0)) && frame_octets == 4'h1;
  endproperty
  a_fmt6: assert property (p_fmt6) else $error("format 6 lane A0 octet wrong");

  property p_fmt15;
    s_pop_plain ##0 (link_format_select == `LMP_FMT_15) |=> lane_data[0 +: 64] == $past(chk_f15);
  endproperty
  a_fmt15: assert property (p_fmt15) else $error("format 15 lane word wrong");

  property p_fmt17;
    pop && !test_mode_active && link_format_select == `LMP_FMT_17 |=>
      lane_data[HALF*LW+56 +: 8] == $past(chk_ai1) && lane_data[56 +: 8] == $past(chk_ai0) &&
      frame_octets == 4'h1;
  endproperty
  a_fmt17: assert property (p_fmt17) else $error("format 17 mapping or binding wrong");

  property p_pin_pd;
    st.pd_sync |-> !lane_valid ##1 (lane_power == 16'h0000);
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("lanes alive under powerdown pin");

  property p_mode_pd;
    device_power_mode[7:1] != 7'h00 |=> lane_power == 16'h0000;
  endproperty
  a_mode_pd: assert property (p_mode_pd) else $error("lanes alive under power mode");

  property p_chan_pd;
    chan_a_powerdown |=> lane_power[HALF-1:0] == 8'h00;
  endproperty
  a_chan_pd: assert property (p_chan_pd) else $error("link A lanes alive with channel A down");

  property p_unused;
    norm && !keep && link_format_select == `LMP_FMT_7 |=> lane_power == 16'h0F0F;
  endproperty
  a_unused: assert property (p_unused) else $error("format 7 lane power pattern wrong");

  property p_keep;
    norm && keep |=> lane_power == 16'hFFFF;
  endproperty
  a_keep: assert property (p_keep) else $error("spare lanes not kept alive");

  property p_test_power;
    norm && !keep && test_mode_active && link_format_select == `LMP_FMT_6 |=> lane_power == 16'h0303;
  endproperty
  a_test_power: assert property (p_test_power) else $error("test mode changed lane power");
endmodule
`default_nettype wire

//--- rtl/lmp_params.svh
`ifndef LMP_PARAMS_SVH
`define LMP_PARAMS_SVH
// ****************************************
// Geometry
// ****************************************
`define LMP_SAMP_W 16
`define LMP_SAMPS 20
`define LMP_LANES 16
`define LMP_LANE_W 64
`define LMP_FIFO_DEPTH 32
// ****************************************
// Link format codes
// ****************************************
`define LMP_FMT_6 5'h06
`define LMP_FMT_7 5'h07
`define LMP_FMT_9 5'h09
`define LMP_FMT_10 5'h0A
`define LMP_FMT_11 5'h0B
`define LMP_FMT_12 5'h0C
`define LMP_FMT_13 5'h0D
`define LMP_FMT_14 5'h0E
`define LMP_FMT_15 5'h0F
`define LMP_FMT_16 5'h10
`define LMP_FMT_17 5'h11
`define LMP_FMT_18 5'h12
// ****************************************
// Power mode values that keep lanes alive
// ****************************************
`define LMP_PMODE_RUN0 8'h00
`define LMP_PMODE_RUN1 8'h01
// ****************************************
// Reset values
// ****************************************
`define LMP_RST_RAMP 8'h00
`define LMP_RST_POWER 16'h0000
`endif

//--- rtl/lmp_pkg.sv
`include "lmp_params.svh"
package lmp_pkg;
  typedef logic [4:0] lmp_fmt_type;
  typedef logic [`LMP_LANES*`LMP_LANE_W-1:0] lmp_lanes_type;
  typedef logic [`LMP_SAMPS*`LMP_SAMP_W-1:0] lmp_samps_type;
  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic out_valid;
    lmp_lanes_type lane_data;
    logic [3:0] frame_octets;
    logic [`LMP_LANES-1:0] lane_power;
    logic [7:0] ramp;
  } lmp_top_state_type;
endpackage

//--- sim/lane_map_power_test_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bench signals
// ****************************************
module lane_map_power_test_ctrl_tb_top;
  typedef struct packed {
    logic [1023:0] w;
    logic [1023:0] m;
    logic [3:0] oc;
  } lmp_exp_type;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic in_valid = 1'b0;
  logic ra = 1'b0, rb = 1'b0, cpa = 1'b0, cpb = 1'b0, pin = 1'b0, ka = 1'b0, kb = 1'b0;
  logic [319:0] ai = '0, aq = '0, bi = '0, bq = '0;
  logic [4:0] fmt = 5'h06;
  logic [7:0] pmode = 8'h00;
  logic [3:0] tsel = 4'h0;
  logic [1:0] rx_mode = 2'h1;
  logic [31:0] rng = 32'h0000_95a8;
  logic [7:0] tcnt = 8'h00;
  int errors = 0, checks_done = 0, nf;
  bit ok;
  lmp_exp_type q[$];
  lmp_exp_type e, o;
  wire logic in_ready, lane_valid, lane_ready, test_mode_active;
  wire logic [1023:0] lane_data;
  wire logic [3:0] frame_octets;
  wire logic [15:0] lane_power;
  logic [4:0] codes[12] = '{5'h06, 5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12};
  logic [16:0] pt[9] = '{{4'h8, 5'h07, 8'h00}, {4'h4, 5'h07, 8'h00}, {4'h2, 5'h07, 8'h00},
    {4'h3, 5'h07, 8'h00}, {4'hB, 5'h07, 8'h00}, {4'h0, 5'h07, 8'h02}, {4'h0, 5'h07, 8'h01},
    {4'h0, 5'h08, 8'h00}, {4'h0, 5'h07, 8'h00}};
  always #5 clk_sys = ~clk_sys;
  lmp_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .in_valid(in_valid), .in_ready(in_ready),
    .samp_a_i(ai), .samp_a_q(aq), .samp_b_i(bi), .samp_b_q(bq), .link_format_select(fmt),
    .chan_a_route_select(ra), .chan_b_route_select(rb), .chan_a_powerdown(cpa), .chan_b_powerdown(cpb),
    .full_powerdown_pin(pin), .device_power_mode(pmode), .spare_lane_keepalive_a(ka),
    .spare_lane_keepalive_b(kb), .test_pattern_select(tsel), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_data(lane_data), .frame_octets(frame_octets),
    .lane_power(lane_power), .test_mode_active(test_mode_active));
  lmp_rx_model rx (.clk_sys(clk_sys), .mode(rx_mode), .lane_ready(lane_ready));
  // ****************************************
  // Expectations
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic void put(input int ln, input int off, input int wd, input logic [15:0] v);
    for (int b = 0; b < wd; b++) begin
      e.w[64*ln+63-off-b] = v[wd-1-b];
      e.m[64*ln+63-off-b] = 1'b1;
    end
  endfunction
  function automatic int nl(input logic [4:0] f);
    case (f)
      5'h06, 5'h0A, 5'h0E: return 2;
      5'h07, 5'h09, 5'h0B: return 4;
      5'h0C, 5'h11, 5'h12: return 8;
      5'h0D, 5'h0F, 5'h10: return 1;
      default: return 0;
    endcase
  endfunction
  function automatic logic [15:0] pw();
    logic [7:0] a;
    logic [7:0] b;
    a = 8'((1 << nl(fmt)) - 1);
    b = (fmt == 5'h0F) ? 8'h00 : a;
    if (ka && kb) begin
      a = 8'hFF;
      b = 8'hFF;
    end
    if (cpa) a = 8'h00;
    if (cpb) b = 8'h00;
    if (pin || pmode > 8'h01) return 16'h0000;
    return {b, a};
  endfunction
  task automatic mk(input logic [319:0] a0, a1, b0, b1);
    logic [319:0] pi, pq, si, sq;
    int n;
    e = '0;
    pi = ra ? b0 : a0;
    pq = ra ? b1 : a1;
    si = rb ? a0 : b0;
    sq = rb ? a1 : b1;
    n = nl(fmt);
    case (fmt)
      5'h06, 5'h07, 5'h09, 5'h12: begin
        e.oc = (fmt == 5'h09) ? 4'h2 : 4'h1;
        for (int k = 0; k < n; k++) begin
          put(k, 0, 8 * e.oc, pi[16*k+:16]);
          put(8 + k, 0, 8 * e.oc, si[16*k+:16]);
        end
      end
      5'h0A, 5'h0B, 5'h0E: begin
        e.oc = 4'h2;
        for (int k = 0; k < n / 2; k++) begin
          put(k, 0, 16, pi[16*k+:16]);
          put(k + n / 2, 0, 16, pq[16*k+:16]);
          put(8 + k, 0, 16, si[16*k+:16]);
          put(8 + k + n / 2, 0, 16, sq[16*k+:16]);
        end
      end
      5'h0D, 5'h0F, 5'h10: begin
        e.oc = (fmt == 5'h0F) ? 4'h8 : 4'h4;
        put(0, 0, 16, pi[15:0]);
        put(0, 16, 16, pq[15:0]);
        put((fmt == 5'h0F) ? 0 : 8, (fmt == 5'h0F) ? 32 : 0, 16, si[15:0]);
        put((fmt == 5'h0F) ? 0 : 8, (fmt == 5'h0F) ? 48 : 16, 16, sq[15:0]);
      end
      5'h0C: begin
        e.oc = 4'h8;
        for (int k = 0; k < 4; k++) begin
          for (int j = 0; j < 5; j++) begin
            put(2 * k, 12 * j, 12, pi[16*(k+4*j)+:16]);
            put(2 * k + 1, 12 * j, 12, pq[16*(k+4*j)+:16]);
            put(8 + 2 * k, 12 * j, 12, si[16*(k+4*j)+:16]);
            put(9 + 2 * k, 12 * j, 12, sq[16*(k+4*j)+:16]);
          end
        end
        for (int l = 0; l < 16; l++) put(l, 60, 4, 16'h0000);
      end
      5'h11: begin
        e.oc = 4'h1;
        for (int k = 0; k < 8; k++) begin
          put(k, 0, 8, a0[32*k+:16]);
          put(8 + k, 0, 8, a0[32*k+16+:16]);
        end
      end
      default: e.oc = 4'h0;
    endcase
    if (tsel != 4'h0) begin
      e.w = {128{tcnt}};
      tcnt = tcnt + 8'h01;
    end
    q.push_back(e);
  endtask
  // ****************************************
  // Driving and checking
  // ****************************************
  task automatic end_of_test();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail();
    errors++;
    $display("[ERR] t=%0t got=%0h exp=%0h wait ran out", $time, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic chk(input logic [1023:0] got, input logic [1023:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic push(input int lim, output bit okp);
    logic [319:0] v[4];
    okp = 1'b0;
    for (int i = 0; i < 40; i++) begin
      rng = xs(rng);
      v[i/10][32*(i%10)+:32] = rng;
    end
    in_valid <= 1'b1;
    ai <= v[0];
    aq <= v[1];
    bi <= v[2];
    bq <= v[3];
    for (int t = 0; t < lim && !okp; t++) begin
      @(negedge clk_sys);
      okp = (in_ready === 1'b1);
    end
    if (okp) begin
      @(posedge clk_sys);
      mk(v[0], v[1], v[2], v[3]);
    end
  endtask
  task automatic send(input int n);
    bit okp;
    @(posedge clk_sys);
    repeat (n) begin
      push(200, okp);
      if (!okp) fail();
    end
    in_valid <= 1'b0;
  endtask
  task automatic drain();
    int t;
    for (t = 0; t < 500 && q.size() != 0; t++) @(posedge clk_sys);
    if (t == 500) fail();
  endtask
  // Four edges cover the pin synchroniser and the registered enables
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (!sys_rst && lane_valid === 1'b1 && lane_ready === 1'b1) begin
      if (q.size() == 0) begin
        chk(lane_data, '0);
      end else begin
        o = q.pop_front();
        chk(lane_data & o.m, o.w & o.m);
        chk(frame_octets, o.oc);
      end
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk({lane_power, lane_valid, in_ready, test_mode_active}, 19'h0_0002);
    foreach (codes[i]) begin
      @(posedge clk_sys);
      fmt <= codes[i];
      settle();
      chk(lane_power, pw());
      send(3);
      drain();
    end
    @(posedge clk_sys);
    fmt <= 5'h12;
    ra <= 1'b1;
    send(2);
    drain();
    @(posedge clk_sys);
    rb <= 1'b1;
    send(2);
    drain();
    @(posedge clk_sys);
    fmt <= 5'h11;
    send(2);
    drain();
    @(posedge clk_sys);
    ra <= 1'b0;
    rb <= 1'b0;
    foreach (pt[i]) begin
      @(posedge clk_sys);
      {cpa, cpb, ka, kb, fmt, pmode} <= pt[i];
      settle();
      chk(lane_power, pw());
    end
    @(posedge clk_sys);
    rx_mode <= 2'h2;
    send(1);
    settle();
    chk(lane_valid, 1'b1);
    @(posedge clk_sys);
    pin <= 1'b1;
    settle();
    chk({lane_valid, lane_power}, 17'h0_0000);
    @(posedge clk_sys);
    pin <= 1'b0;
    settle();
    @(posedge clk_sys);
    rx_mode <= 2'h0;
    drain();
    @(posedge clk_sys);
    rx_mode <= 2'h2;
    @(posedge clk_sys);
    for (nf = 0; nf < 40; nf++) begin
      push(3, ok);
      if (!ok) break;
    end
    @(posedge clk_sys);
    in_valid <= 1'b0;
    rx_mode <= 2'h1;
    chk(nf, 33);
    drain();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    fmt <= 5'h06;
    tsel <= 4'h3;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tcnt = 8'h00;
    settle();
    chk({test_mode_active, lane_power}, {1'b1, pw()});
    send(3);
    drain();
    end_of_test();
  end
endmodule
`default_nettype wire

//--- sim/lmp_rx_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Receiver side of the lanes
// ****************************************
module lmp_rx_model (
  input wire logic clk_sys,
  input wire logic [1:0] mode,
  output var logic lane_ready
);
  logic [2:0] cnt = 3'h0;
  // Mode 0 takes every word, 1 stalls often, 2 holds off while relinking
  always_ff @(posedge clk_sys) begin
    cnt <= cnt + 3'h1;
    lane_ready <= (mode == 2'h0) || (mode == 2'h1 && (cnt[0] ^ cnt[2]));
  end
endmodule
`default_nettype wire
